// ### hw/start_marker_detect.sv
`timescale 1ns/1ns
// Turns the raw marker photocell into one pulse per pass, only while tape moves
module start_marker_detect
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic marker_sensor,
  input wire logic tape_moving,
  output logic start_marker_pulse
);

  logic sync1;
  logic sync2;
  logic seen;
  logic next_pulse;

  // Edge of the second stage only; a stopped tape gives no pulse
  always_comb
  begin
    next_pulse = sync2 && !seen && tape_moving; // [RULE_10]
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      seen <= 1'b0;
      start_marker_pulse <= 1'b0;
    end
    else
    begin
      sync1 <= marker_sensor;
      sync2 <= sync1;
      seen <= sync2;
      start_marker_pulse <= next_pulse;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_marker_single: assert property (start_marker_pulse |=> !start_marker_pulse) // [RULE_10]
    else $error("marker pulse longer than one cycle");
  a_marker_stopped: assert property (!$past(tape_moving) |-> !start_marker_pulse) // [RULE_10]
    else $error("marker pulse while tape stopped");

endmodule

// ### hw/tape_load_rewind_sequencer.sv
`timescale 1ns/1ns
`include "tape_seq_defines.svh"
// Functional notes
// RULE_01: Marker sets origin flag, halting both motion requests
// RULE_02: Threading clears on marker after four gaps
// RULE_03: Marker while loading starts initial rewind
// RULE_04: Rewind sets reverse direction, tape goes backward
// RULE_05: Columns settled ends the loading operation
// RULE_06: Pneumatic motor runs while settled, ready, filled
// RULE_07: Start sets ready latch; lamp needs door shut
// RULE_08: Erase or write current fault drops ready
// RULE_09: Only current model select line driven low
// RULE_10: Marker gives one pulse, none when stopped
// RULE_11: Settled columns request slow rewind to origin
// RULE_12: Filled only with loops inside all limits
// RULE_13: Panel reset clears ready, motion, goes idle
module tape_load_rewind_sequencer
  import tape_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
  parameter int MODEL_COUNT = `MODEL_COUNT
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic marker_sensor,
  input wire sense_t sense,
  input wire logic [1:0] model_code,
  output status_t status,
  output logic [MODEL_COUNT-1:0] model_sel_n
);

  localparam int SENSE_W = $bits(sense_t);

  // Counter widths bound the parameters: 12-bit settle count, 2-bit model code
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 4095)
  begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end
  if (MODEL_COUNT < 1 || MODEL_COUNT > 4)
  begin : g_bad_models
    $error("MODEL_COUNT out of range");
  end

  logic [SENSE_W-1:0] sync1;
  logic [SENSE_W-1:0] sync2;
  sense_t s;
  sense_t prev;
  logic start_marker_pulse;
  logic lr_edge;
  logic start_edge;
  logic reset_edge;
  logic gap_edge;
  logic filled_now;
  logic head_fault;
  seq_state_t state;
  seq_state_t next_state;
  status_t next_status;
  logic [2:0] gap_cnt;
  logic [2:0] next_gap_cnt;
  logic [11:0] settle_cnt;
  logic [11:0] next_settle_cnt;
  logic [MODEL_COUNT-1:0] next_model_sel_n;

  // Two-stage synchronisers, one per sense pin
  genvar gi;
  generate
    for (gi = 0; gi < SENSE_W; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (!rstn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= sense[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign s = sense_t'(sync2);

  // Previous stage for push and gap edges; a held button acts once
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      prev <= '0;
    else
      prev <= s;
  end

  assign lr_edge = s.load_rewind_btn && !prev.load_rewind_btn;
  assign start_edge = s.start_btn && !prev.start_btn;
  assign reset_edge = s.reset_btn && !prev.reset_btn;
  assign gap_edge = s.inter_record_gap && !prev.inter_record_gap;
  assign filled_now = s.left_below_top && s.left_above_bottom &&
                      s.right_below_top && s.right_above_bottom; // [RULE_12]
  assign head_fault = s.writing && (s.erase_fault || s.write_fault);

  start_marker_detect u_marker
  (
    .mclk(mclk),
    .rstn(rstn),
    .marker_sensor(marker_sensor),
    .tape_moving(status.motion_req || status.ext_motion_req), // [RULE_10]
    .start_marker_pulse(start_marker_pulse)
  );

  // Load, rewind and ready sequencing
  always_comb
  begin
    next_state = state;
    next_status = status;
    next_gap_cnt = gap_cnt;
    next_settle_cnt = settle_cnt;
    // Settling restarts whenever a loop leaves its limits, so bobbles do not count
    if (!filled_now)
      next_settle_cnt = 12'h000;
    else if (settle_cnt < 12'(SETTLE_CYCLES))
      next_settle_cnt = settle_cnt + 12'h001;
    next_status.columns_filled = filled_now; // [RULE_12]
    next_status.columns_settled = filled_now && (next_settle_cnt == 12'(SETTLE_CYCLES)); // [RULE_12]
    if (start_marker_pulse)
      next_status.at_origin = 1'b1; // [RULE_01]
    case (state)
      ST_IDLE, ST_LOADED:
      begin
        if (lr_edge)
        begin
          next_state = ST_THREAD;
          next_status.loading_operation = 1'b1;
          next_status.threading = 1'b1;
          next_status.ext_motion_req = 1'b1;
          next_status.at_origin = 1'b0;
          next_status.initial_rewind = 1'b0;
          next_status.reverse_dir = 1'b0;
          next_status.ready_latch = 1'b0;
          next_gap_cnt = 3'h0;
        end
      end
      ST_THREAD:
      begin
        if (gap_edge && gap_cnt < 3'(`GAP_COUNT_TO_CLEAR))
          next_gap_cnt = gap_cnt + 3'h1;
        if (start_marker_pulse)
        begin
          next_status.initial_rewind = 1'b1; // [RULE_03]
          if (gap_cnt == 3'(`GAP_COUNT_TO_CLEAR))
            next_status.threading = 1'b0; // [RULE_02]
        end
        else if (status.initial_rewind)
        begin
          // Leaving the marker backward, so origin is no longer held
          next_state = ST_REWIND;
          next_status.rewind_operation = 1'b1; // [RULE_03]
          next_status.reverse_dir = 1'b1; // [RULE_04]
          next_status.at_origin = 1'b0;
        end
      end
      ST_REWIND:
      begin
        if (status.columns_settled)
        begin
          next_status.loading_operation = 1'b0; // [RULE_05]
          next_status.motion_req = !status.at_origin; // [RULE_11]
        end
        if (start_marker_pulse)
        begin
          next_state = ST_LOADED;
          next_status.rewind_operation = 1'b0;
          next_status.initial_rewind = 1'b0;
          next_status.reverse_dir = 1'b0;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    // Origin always wins over any motion request
    if (next_status.at_origin)
    begin
      next_status.motion_req = 1'b0; // [RULE_01]
      next_status.ext_motion_req = 1'b0; // [RULE_01]
    end
    if (head_fault)
      next_status.ready_latch = 1'b0; // [RULE_08]
    else if (start_edge && state == ST_LOADED)
      next_status.ready_latch = 1'b1; // [RULE_07]
    if (reset_edge)
    begin
      next_state = ST_IDLE; // [RULE_13]
      next_status.ready_latch = 1'b0;
      next_status.motion_req = 1'b0;
      next_status.ext_motion_req = 1'b0;
      next_status.loading_operation = 1'b0;
      next_status.threading = 1'b0;
      next_status.initial_rewind = 1'b0;
      next_status.rewind_operation = 1'b0;
      next_status.reverse_dir = 1'b0;
    end
    next_status.pneumatic_motor = next_status.loading_operation ||
      (next_status.columns_settled && s.mech_ready && next_status.columns_filled); // [RULE_06]
    next_status.ready_lamp = next_status.ready_latch && s.door_shut; // [RULE_07]
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      status <= '0;
      gap_cnt <= 3'h0;
      settle_cnt <= 12'h000;
    end
    else
    begin
      state <= next_state;
      status <= next_status;
      gap_cnt <= next_gap_cnt;
      settle_cnt <= next_settle_cnt;
    end
  end

  // Model selects are active low; an unknown code selects none
  always_comb
  begin
    next_model_sel_n = '1;
    for (int i = 0; i < MODEL_COUNT; i++)
      if (model_code == 2'(i))
        next_model_sel_n[i] = 1'b0; // [RULE_09]
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      model_sel_n <= '1;
    else
      model_sel_n <= next_model_sel_n;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_origin_halts: assert property (start_marker_pulse |=> status.at_origin && !status.motion_req && !status.ext_motion_req) // [RULE_01]
    else $error("motion not halted at origin");
  a_thread_clear: assert property ($fell(status.threading) && !$past(reset_edge) |-> $past(start_marker_pulse) && $past(gap_cnt) == 3'h4) // [RULE_02]
    else $error("threading cleared without marker and four gaps");
  a_init_rewind: assert property (state == ST_THREAD && start_marker_pulse && !reset_edge |=> status.initial_rewind ##1 status.rewind_operation) // [RULE_03]
    else $error("initial rewind did not start rewind");
  a_reverse_dir: assert property (status.rewind_operation |-> status.reverse_dir) // [RULE_04]
    else $error("rewind without reverse direction");
  a_settle_ends: assert property (state == ST_REWIND && status.columns_settled && !reset_edge |=> !status.loading_operation) // [RULE_05]
    else $error("loading not ended by settled columns");
  a_pneumatic_run: assert property (status.columns_settled && status.columns_filled && $past(s.mech_ready) |-> status.pneumatic_motor) // [RULE_06]
    else $error("pneumatic motor off while settled");
  a_ready_lamp: assert property (status.ready_lamp |-> status.ready_latch && $past(s.door_shut)) // [RULE_07]
    else $error("lamp without latch and door");
  a_head_fault: assert property (head_fault |=> !status.ready_latch) // [RULE_08]
    else $error("ready kept on head fault");
  a_model_select: assert property ($countones(~model_sel_n) <= 1 and (model_code == 2'h0 |=> !model_sel_n[0])) // [RULE_09]
    else $error("model select wrong");
  a_rewind_motion: assert property (state == ST_REWIND && status.columns_settled && !status.at_origin && !start_marker_pulse && !reset_edge |=> status.motion_req) // [RULE_11]
    else $error("no rewind request after settling");
  a_settled_filled: assert property (status.columns_settled |-> status.columns_filled && $past(filled_now)) // [RULE_12]
    else $error("settled outside column limits");
  a_panel_reset: assert property (reset_edge |=> state == ST_IDLE && !status.ready_latch && !status.motion_req && !status.ext_motion_req) // [RULE_13]
    else $error("panel reset left motion or ready");

  c_rewind_done: cover property (state == ST_REWIND ##1 state == ST_LOADED);
  c_ready_on: cover property (status.ready_lamp);
  c_thread_cleared: cover property ($fell(status.threading) && !$past(reset_edge));
  c_head_fault: cover property (status.ready_latch ##1 !status.ready_latch && $past(head_fault));

endmodule

// ### hw/tape_seq_defines.svh
`ifndef TAPE_SEQ_DEFINES_SVH
`define TAPE_SEQ_DEFINES_SVH

// Clock rate
`define CLK_PERIOD_NS 4
// Gap detections needed before the marker may end threading
`define GAP_COUNT_TO_CLEAR 4
// Columns must read filled this long before they count as settled
`define SETTLE_NS 10000
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Transport models served by the select lines
`define MODEL_COUNT 3

`endif

// ### hw/tape_seq_pkg.sv
package tape_seq_pkg;

  // Raw sense pins, all from outside the clock domain
  typedef struct packed {
    logic load_rewind_btn;
    logic start_btn;
    logic reset_btn;
    logic door_shut;
    logic mech_ready;
    logic erase_fault;
    logic write_fault;
    logic writing;
    logic inter_record_gap;
    logic left_below_top;
    logic left_above_bottom;
    logic right_below_top;
    logic right_above_bottom;
  } sense_t;

  // Sequencer flags and drives
  typedef struct packed {
    logic at_origin;
    logic threading;
    logic initial_rewind;
    logic rewind_operation;
    logic reverse_dir;
    logic loading_operation;
    logic columns_filled;
    logic columns_settled;
    logic motion_req;
    logic ext_motion_req;
    logic pneumatic_motor;
    logic ready_latch;
    logic ready_lamp;
  } status_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_THREAD = 4'b0010,
    ST_REWIND = 4'b0100,
    ST_LOADED = 4'b1000
  } seq_state_t;

endpackage

// ### sim/tape_load_rewind_sequencer_tb.sv
`timescale 1ns/1ns
module tape_load_rewind_sequencer_tb
  import tape_seq_pkg::*;
;
  // Short settle count keeps the run brief
  localparam int SC = 16;
  localparam sense_t LR = 13'h1000;
  localparam sense_t ST = 13'h0800;
  localparam sense_t RB = 13'h0400;
  localparam sense_t ERF = 13'h0080;
  localparam sense_t WRF = 13'h0040;
  localparam sense_t WRG = 13'h0020;
  localparam sense_t GAP = 13'h0010;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic pass = 1'b0;
  logic park = 1'b0;
  logic [1:0] model_code = 2'h3;
  logic [3:0] cols = 4'h0;
  logic [3:0] lim;
  logic marker_sensor;
  sense_t pins = '0;
  sense_t sense;
  status_t status;
  logic [2:0] model_sel_n;
  int n_mismatch = 0;
  int cmp_count = 0;
  // Model code, then the active-low selects it should give
  logic [4:0] rows [4] = '{5'b00110, 5'b01101, 5'b10011, 5'b11111};

  // Clock
  initial
  begin
    forever #2 mclk = ~mclk;
  end

  // Column limits come from the far-side model
  always_comb
  begin
    sense = pins;
    sense[3:0] = lim;
  end

  tape_load_rewind_sequencer #(.SETTLE_CYCLES(SC)) dut (.mclk(mclk), .rstn(rstn),
    .marker_sensor(marker_sensor), .sense(sense), .model_code(model_code),
    .status(status), .model_sel_n(model_sel_n));
  tape_transport_model model (.mclk(mclk), .status(status), .pass(pass), .park(park),
    .cols(cols), .marker_sensor(marker_sensor), .lim(lim));

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Held six cycles so the synchroniser and edge stage both see it
  task automatic press(input sense_t m);
    pins = pins | m;
    tick(6);
    pins = pins & ~m;
    tick(6);
  endtask

  task automatic marker();
    pass = 1'b1;
    tick(1);
    pass = 1'b0;
    tick(12);
  endtask

  task automatic stop_test();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog: the full sequence needs well under a thousand cycles
  initial
  begin
    tick(3000);
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    tick(12);
    rstn = 1'b1;
    tick(1);
    chk(status, 13'h0, "reset status");
    chk(model_sel_n, 3'h7, "reset select");
    for (int i = 0; i < 4; i++)
    begin
      model_code = rows[i][4:3];
      tick(3);
      chk(model_sel_n, rows[i][2:0], "model select");
    end
    pins.mech_ready = 1'b1;
    pins.door_shut = 1'b1;
    // First load with only three gaps, then a panel reset
    press(LR);
    chk(status.loading_operation, 1'b1, "loading_operation");
    chk(status.ext_motion_req, 1'b1, "thread motion");
    repeat (3) press(GAP);
    marker();
    chk(status.threading, 1'b1, "thread kept");
    chk(status.ext_motion_req, 1'b0, "thread halt");
    chk(status.rewind_operation, 1'b1, "rewind");
    chk(status.reverse_dir, 1'b1, "backward");
    press(RB);
    chk(status.rewind_operation | status.motion_req | status.loading_operation, 1'b0, "panel reset");
    // Marker under a stopped tape must not act
    park = 1'b1;
    tick(12);
    park = 1'b0;
    chk(status.at_origin, 1'b0, "stopped marker");
    // Full load with four gaps
    press(LR);
    repeat (4) press(GAP);
    marker();
    chk(status.threading, 1'b0, "thread cleared");
    chk(status.initial_rewind, 1'b1, "initial rewind");
    cols = 4'he;
    tick(SC + 10);
    chk(status.columns_filled | status.columns_settled, 1'b0, "loop outside");
    cols = 4'hf;
    tick(SC + 10);
    chk(status.columns_filled, 1'b1, "filled");
    chk(status.columns_settled, 1'b1, "settled");
    chk(status.loading_operation, 1'b0, "load done");
    chk(status.motion_req, 1'b1, "slow rewind");
    chk(status.pneumatic_motor, 1'b1, "vacuum");
    pins.mech_ready = 1'b0;
    tick(8);
    chk(status.pneumatic_motor, 1'b0, "vacuum gated");
    pins.mech_ready = 1'b1;
    marker();
    chk(status.at_origin, 1'b1, "origin");
    chk(status.motion_req, 1'b0, "halt");
    // Ready, door gating, then each head fault in turn
    for (int f = 0; f < 2; f++)
    begin
      press(ST);
      chk(status.ready_lamp, 1'b1, "lamp");
      pins.door_shut = 1'b0;
      tick(8);
      chk({status.ready_latch, status.ready_lamp}, 2'b10, "door open");
      pins.door_shut = 1'b1;
      // A current fault counts only while writing
      press(f ? WRF : ERF);
      chk(status.ready_latch, 1'b1, "fault not writing");
      press(WRG | (f ? WRF : ERF));
      chk(status.ready_latch, 1'b0, "head fault");
    end
    // Mid-run reset returns every output to its reset value
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(1);
    chk(status, 13'h0, "mid reset status");
    chk(model_sel_n, 3'h7, "mid reset select");
    stop_test();
  end
endmodule

// ### sim/tape_transport_model.sv
`timescale 1ns/1ns
// Far side: start marker photocell and the four vacuum column switches
module tape_transport_model
  import tape_seq_pkg::*;
(
  input wire logic mclk,
  input wire status_t status,
  input wire logic pass,
  input wire logic park,
  input wire logic [3:0] cols,
  output logic marker_sensor,
  output logic [3:0] lim
);
  logic [2:0] cnt = 3'h0;

  // The marker crosses the cell only while a motion request moves tape
  always @(posedge mclk)
  begin
    if (pass && (status.motion_req || status.ext_motion_req))
      cnt <= 3'h4;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end

  // Tape parked on the marker keeps the cell dark, so the detector must gate it
  assign marker_sensor = park || (cnt != 3'h0);
  // Loop positions as the bench places them
  assign lim = cols;
endmodule
